/* File: core/rsb_pkg.sv */
// Shared constants and types for the rotate / subtract-with-borrow / special-page datapath.
// Assumes a single 100 MHz clock and a synchronous active-low reset.
package rsb_pkg;

  localparam int          DATA_W       = 8;
  localparam int          FILE_DEPTH   = 128;
  localparam int          FILE_AW      = 7;
  localparam int          SP_DEPTH     = 32;
  localparam int          SP_AW        = 5;
  localparam logic        DEST_WORKING = 1'b0;
  localparam logic        DEST_FILE    = 1'b1;
  localparam logic [7:0]  ACC_RST      = 8'h00;
  localparam logic        FLAG_RST     = 1'b0;
  localparam logic [7:0]  RESULT_ZERO  = 8'h00;
  localparam int          HALF_POS     = 4;
  localparam int          OP_CYCLES    = 1;

  typedef enum logic [2:0] {
    OP_IDLE,
    OP_ROTATE_RIGHT,
    OP_SBC_REG,
    OP_SBC_IMM,
    OP_SP_READ
  } rsb_op_t;

  // True for both subtract-with-borrow forms, which update all three flags
  function automatic logic is_sbc(input rsb_op_t op);
    return (op == OP_SBC_REG) || (op == OP_SBC_IMM);
  endfunction : is_sbc

  // True for the forms whose result may go back to the file register
  function automatic logic uses_dest(input rsb_op_t op);
    return (op == OP_ROTATE_RIGHT) || (op == OP_SBC_REG);
  endfunction : uses_dest

endpackage : rsb_pkg

/* File: core/rsb_alu.sv */
// Combinational result and flag generation for rotate and subtract-with-borrow.
// Assumes operands are already selected and held stable by the caller.
module rsb_alu
  import rsb_pkg::*;
(
  input  rsb_pkg::rsb_op_t    op,
  input  wire logic [7:0]     file_val,
  input  wire logic [7:0]     imm,
  input  wire logic [7:0]     acc,
  input  wire logic           carry_in,
  output logic      [7:0]     result,
  output logic                carry_out,
  output logic                zero_out,
  output logic                half_out
);

  logic [7:0] operand;
  logic [8:0] sum;
  logic [4:0] low_sum;

  always_comb
  begin
    operand   = (op == OP_SBC_IMM) ? imm : file_val;
    // Borrow is encoded inverted: the add of the complement carries out when none occurs
    sum       = {1'b0, operand} + {1'b0, ~acc} + {8'h00, carry_in};
    low_sum   = {1'b0, operand[3:0]} + {1'b0, ~acc[3:0]} + {4'h0, carry_in};
    result    = sum[7:0];
    carry_out = sum[8];
    zero_out  = (sum[7:0] == RESULT_ZERO);
    half_out  = low_sum[HALF_POS];
    if (op == OP_ROTATE_RIGHT)
    begin
      result    = {carry_in, file_val[7:1]};
      carry_out = file_val[0];
      zero_out  = 1'b0;
      half_out  = 1'b0;
    end
  end

endmodule : rsb_alu

/* File: core/rsb_core.sv */
// Working register, flags, file registers and special-page registers with one-cycle
// execution of rotate-right, subtract-with-borrow and special-page read.
// Assumes the surrounding core presents one decoded operation per clock on op_valid.
module rsb_core
  import rsb_pkg::*;
#(
  parameter int FILE_N = FILE_DEPTH,
  parameter int SP_N   = SP_DEPTH
)
(
  input  wire logic               clk_sys,
  input  wire logic               rst_n,
  input  wire logic               op_valid,
  input  rsb_pkg::rsb_op_t        op_code,
  input  wire logic [FILE_AW-1:0] file_addr,
  input  wire logic               dest_sel,
  input  wire logic [7:0]         imm,
  input  wire logic [SP_AW-1:0]   sp_index,
  input  wire logic               load_acc_en,
  input  wire logic [7:0]         load_acc_data,
  input  wire logic               load_carry_en,
  input  wire logic               load_carry,
  input  wire logic               load_file_en,
  input  wire logic [FILE_AW-1:0] load_file_addr,
  input  wire logic [7:0]         load_file_data,
  input  wire logic               load_sp_en,
  input  wire logic [SP_AW-1:0]   load_sp_index,
  input  wire logic [7:0]         load_sp_data,
  input  wire logic [FILE_AW-1:0] peek_addr,
  output logic      [7:0]         peek_data,
  output logic      [7:0]         working_register,
  output logic                    carry_flag,
  output logic                    zero_flag,
  output logic                    half_carry_flag,
  output logic                    op_done
);

  logic [7:0] file_mem [FILE_N];
  logic [7:0] sp_mem   [SP_N];

  logic [7:0] acc_q, acc_d;
  logic       carry_q, carry_d;
  logic       zero_q, zero_d;
  logic       half_q, half_d;
  logic       done_q, done_d;
  logic [7:0] peek_q, peek_d;

  logic [7:0]         file_rd;
  logic [7:0]         sp_rd;
  logic [7:0]         alu_res;
  logic               alu_c;
  logic               alu_z;
  logic               alu_h;
  logic               file_we;
  logic [FILE_AW-1:0] file_wa;
  logic [7:0]         file_wd;

  assign file_rd = file_mem[file_addr];
  assign sp_rd   = sp_mem[sp_index];

  rsb_alu u_alu (
    .op        (op_code),
    .file_val  (file_rd),
    .imm       (imm),
    .acc       (acc_q),
    .carry_in  (carry_q),
    .result    (alu_res),
    .carry_out (alu_c),
    .zero_out  (alu_z),
    .half_out  (alu_h)
  );

  // Operations take priority; the load ports only act in cycles with op_valid low
  always_comb
  begin
    acc_d   = acc_q;
    carry_d = carry_q;
    zero_d  = zero_q;
    half_d  = half_q;
    done_d  = op_valid && (op_code != OP_IDLE);
    peek_d  = file_mem[peek_addr];
    file_we = 1'b0;
    file_wa = file_addr;
    file_wd = alu_res;
    if (op_valid)
    begin
      unique case (op_code)
        OP_IDLE: ;
        OP_ROTATE_RIGHT, OP_SBC_REG:
        begin
          if (dest_sel == DEST_FILE)
            file_we = 1'b1;
          else
            acc_d = alu_res;
          carry_d = alu_c;
          if (is_sbc(op_code))
          begin
            zero_d = alu_z;
            half_d = alu_h;
          end
        end
        OP_SBC_IMM:
        begin
          acc_d   = alu_res;
          carry_d = alu_c;
          zero_d  = alu_z;
          half_d  = alu_h;
        end
        OP_SP_READ:
          acc_d = sp_rd;
      endcase
    end
    else
    begin
      if (load_acc_en)
        acc_d = load_acc_data;
      if (load_carry_en)
        carry_d = load_carry;
      if (load_file_en)
      begin
        file_we = 1'b1;
        file_wa = load_file_addr;
        file_wd = load_file_data;
      end
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      acc_q   <= ACC_RST;
      carry_q <= FLAG_RST;
      zero_q  <= FLAG_RST;
      half_q  <= FLAG_RST;
      done_q  <= 1'b0;
      peek_q  <= ACC_RST;
    end
    else
    begin
      acc_q   <= acc_d;
      carry_q <= carry_d;
      zero_q  <= zero_d;
      half_q  <= half_d;
      done_q  <= done_d;
      peek_q  <= peek_d;
    end
  end

  // Storage arrays carry no reset; software must initialise them before use
  always_ff @(posedge clk_sys)
  begin
    if (file_we)
      file_mem[file_wa] <= file_wd;
  end

  // Special-page registers are never written by a read, only by the load port
  always_ff @(posedge clk_sys)
  begin
    if (load_sp_en && !op_valid)
      sp_mem[load_sp_index] <= load_sp_data;
  end

  assign working_register = acc_q;
  assign carry_flag       = carry_q;
  assign zero_flag        = zero_q;
  assign half_carry_flag  = half_q;
  assign op_done          = done_q;
  assign peek_data        = peek_q;

  // Reference values computed apart from the datapath, for the checks below
  logic [8:0] ref_reg_sum;
  logic [8:0] ref_imm_sum;
  assign ref_reg_sum = {1'b0, file_rd} + {1'b0, ~acc_q} + {8'h00, carry_q};
  assign ref_imm_sum = {1'b0, imm} + {1'b0, ~acc_q} + {8'h00, carry_q};

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_n);

  sequence s_rotate(logic d);
    op_valid && (op_code == OP_ROTATE_RIGHT) && (dest_sel == d);
  endsequence

  sequence s_sbc_reg(logic d);
    op_valid && (op_code == OP_SBC_REG) && (dest_sel == d);
  endsequence

  chk_rotate_acc_value: assert property (
    s_rotate(DEST_WORKING) |=> (acc_q == {$past(carry_q), $past(file_rd[7:1])})
                               && (carry_q == $past(file_rd[0])))
    else $error("rotate right result or carry wrong");

  chk_dest_file_keep: assert property (
    (s_rotate(DEST_FILE) or s_sbc_reg(DEST_FILE)) |=> $stable(acc_q))
    else $error("working register changed for file destination");

  chk_rotate_file_addr: assert property (
    s_rotate(DEST_FILE) |=>
      (file_mem[$past(file_addr)] == {$past(carry_q), $past(file_rd[7:1])}))
    else $error("rotate result not stored at addressed file register");

  chk_sbc_reg_sum: assert property (
    s_sbc_reg(DEST_WORKING) |=> (acc_q == $past(ref_reg_sum[7:0]))
                                && (carry_q == $past(ref_reg_sum[8])))
    else $error("register subtract with borrow sum wrong");

  chk_sbc_borrow_zero: assert property (
    s_sbc_reg(DEST_WORKING) |=>
      (carry_q == ($past({1'b0, file_rd}) + $past({8'h00, carry_q}) > $past({1'b0, acc_q})))
      && (zero_q == (acc_q == RESULT_ZERO)))
    else $error("borrow or zero flag wrong after subtract");

  chk_sbc_imm_acc: assert property (
    (op_valid && op_code == OP_SBC_IMM) |=> (acc_q == $past(ref_imm_sum[7:0]))
      && (half_q == ($past({1'b0, imm[3:0]}) + $past({1'b0, ~acc_q[3:0]})
                     + $past({4'h0, carry_q}) > 5'h0F)))
    else $error("immediate subtract with borrow wrong");

  chk_sp_read_flags: assert property (
    (op_valid && op_code == OP_SP_READ) |=> (acc_q == $past(sp_rd))
      && $stable(carry_q) && $stable(zero_q) && $stable(half_q))
    else $error("special page read wrong or flags disturbed");

  chk_single_cycle: assert property (
    (op_valid && op_code != OP_IDLE) |=>
      op_done ##1 (op_done == $past(op_valid && op_code != OP_IDLE)))
    else $error("operation did not complete in one cycle");

endmodule : rsb_core

/* File: tb/test_rotate_subtract_sfr_move_ops.sv */
// Self-checking bench for rsb_core: rotate, subtract-with-borrow and special-page read.
// Assumes rsb_pkg is compiled first; the bench drives every port itself.
module test_rotate_subtract_sfr_move_ops;
  timeunit 1ns;
  timeprecision 100ps;
  import rsb_pkg::*;

  logic           clk_sys        = 1'b0;
  logic           rst_n          = 1'b0;
  logic           op_valid       = 1'b0;
  rsb_op_t        op_code        = OP_IDLE;
  logic [6:0]     file_addr      = 7'h00;
  logic           dest_sel       = 1'b0;
  logic [7:0]     imm            = 8'h00;
  logic [4:0]     sp_index       = 5'h00;
  logic           load_acc_en    = 1'b0;
  logic [7:0]     load_acc_data  = 8'h00;
  logic           load_carry_en  = 1'b0;
  logic           load_carry     = 1'b0;
  logic           load_file_en   = 1'b0;
  logic [6:0]     load_file_addr = 7'h00;
  logic [7:0]     load_file_data = 8'h00;
  logic           load_sp_en     = 1'b0;
  logic [4:0]     load_sp_index  = 5'h00;
  logic [7:0]     load_sp_data   = 8'h00;
  logic [6:0]     peek_addr      = 7'h00;
  logic [7:0]     peek_data;
  logic [7:0]     working_register;
  logic           carry_flag;
  logic           zero_flag;
  logic           half_carry_flag;
  logic           op_done;
  int             num_errors     = 0;
  int             samples_checked = 0;

  rsb_core i_rsb_core (.clk_sys, .rst_n, .op_valid, .op_code, .file_addr, .dest_sel, .imm,
    .sp_index, .load_acc_en, .load_acc_data, .load_carry_en, .load_carry, .load_file_en,
    .load_file_addr, .load_file_data, .load_sp_en, .load_sp_index, .load_sp_data,
    .peek_addr, .peek_data, .working_register, .carry_flag, .zero_flag, .half_carry_flag,
    .op_done);

  initial
  begin
    forever #5 clk_sys = ~clk_sys;
  end

  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    samples_checked++;
    if (g !== e)
    begin
      num_errors++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic wrap_up();
    if (num_errors == 0 && samples_checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : wrap_up

  task automatic step();
    @(posedge clk_sys);
    #1;
  endtask : step

  // Flags packed as zero, half-carry, carry
  function automatic logic [7:0] flg();
    return {5'h00, zero_flag, half_carry_flag, carry_flag};
  endfunction : flg

  // Returns {half, carry, result} of r + ~w + c
  function automatic logic [9:0] sbc_exp(input logic [7:0] r, input logic [7:0] w,
                                         input logic c);
    logic [8:0] s;
    logic [4:0] h;
    s = {1'b0, r} + {1'b0, ~w} + 9'(c);
    h = {1'b0, r[3:0]} + {1'b0, ~w[3:0]} + 5'(c);
    return {h[4], s[8], s[7:0]};
  endfunction : sbc_exp

  task automatic ld(input logic [7:0] a, input logic c);
    load_acc_en = 1'b1;
    load_acc_data = a;
    load_carry_en = 1'b1;
    load_carry = c;
    step();
    load_acc_en = 1'b0;
    load_carry_en = 1'b0;
  endtask : ld

  task automatic ldf(input logic [6:0] a, input logic [7:0] v);
    load_file_en = 1'b1;
    load_file_addr = a;
    load_file_data = v;
    step();
    load_file_en = 1'b0;
  endtask : ldf

  task automatic run(input rsb_op_t o, input logic [6:0] a, input logic d,
                     input logic [7:0] i, input logic [4:0] s);
    op_valid = 1'b1;
    op_code = o;
    file_addr = a;
    dest_sel = d;
    imm = i;
    sp_index = s;
    peek_addr = a;
    step();
    op_valid = 1'b0;
    chk("op_done", 8'h01, {7'h00, op_done});
  endtask : run

  task automatic t_rot();
    ld(8'h05, 1'b0);
    run(OP_SBC_IMM, 7'h00, 1'b0, 8'h06, 5'h00);
    ld(8'h3C, 1'b0);
    ldf(7'h7F, 8'hA5);
    run(OP_ROTATE_RIGHT, 7'h7F, 1'b1, 8'h00, 5'h00);
    chk("rot acc", 8'h3C, working_register);
    chk("rot flags", 8'h07, flg());
    step();
    chk("rot file", 8'h52, peek_data);
    chk("op_done low", 8'h00, {7'h00, op_done});
    ldf(7'h00, 8'h01);
    run(OP_ROTATE_RIGHT, 7'h00, 1'b0, 8'h00, 5'h00);
    chk("rot acc", 8'h80, working_register);
    chk("rot flags", 8'h07, flg());
  endtask : t_rot

  task automatic t_sbc(input rsb_op_t o);
    logic [9:0] e;
    logic [7:0] r;
    logic [7:0] w;
    logic       d;
    logic       to_file;
    for (int k = 0; k < 4; k++)
    begin
      r = k[1] ? 8'h06 : 8'h05;
      w = k[1] ? 8'h05 : 8'h06;
      d = k[1] ^ k[0];
      to_file = (o == OP_SBC_REG) && d;
      e = sbc_exp(r, w, k[0]);
      ldf({7{k[1]}}, r);
      ld(w, k[0]);
      run(o, {7{k[1]}}, d, r, 5'h00);
      chk("sbc acc", to_file ? w : e[7:0], working_register);
      chk("sbc flags", {5'h00, e[7:0] == 8'h00, e[9:8]}, flg());
      step();
      chk("sbc file", to_file ? e[7:0] : r, peek_data);
    end
  endtask : t_sbc

  task automatic t_sp();
    load_sp_en = 1'b1;
    load_sp_index = 5'h1F;
    load_sp_data = 8'h55;
    step();
    load_sp_en = 1'b0;
    ld(8'h05, 1'b0);
    run(OP_SBC_IMM, 7'h00, 1'b0, 8'h06, 5'h00);
    step();
    run(OP_SP_READ, 7'h00, 1'b0, 8'h00, 5'h1F);
    chk("sp acc", 8'h55, working_register);
    chk("sp flags", 8'h07, flg());
    step();
    op_valid = 1'b1;
    op_code = OP_IDLE;
    step();
    op_valid = 1'b0;
    chk("idle done", 8'h00, {7'h00, op_done});
    ld(8'hAA, 1'b1);
    run(OP_SP_READ, 7'h00, 1'b0, 8'h00, 5'h1F);
    chk("sp again", 8'h55, working_register);
  endtask : t_sp

  // Hang guard: far above the roughly 70 cycles the sequence needs
  initial
  begin
    #100us;
    num_errors++;
    wrap_up();
  end

  initial
  begin
    repeat (20) @(posedge clk_sys);
    #1;
    rst_n = 1'b1;
    chk("acc reset", 8'h00, working_register);
    chk("flags reset", 8'h00, flg());
    t_rot();
    t_sbc(OP_SBC_REG);
    t_sbc(OP_SBC_IMM);
    t_sp();
    wrap_up();
  end

endmodule : test_rotate_subtract_sfr_move_ops
